// >>> rtl/io_image_pkg.sv
// constants and types shared by the process-image design files
package io_image_pkg;

   // ==========================================
   // connection types
   typedef enum logic [1:0] {
      conn_none,
      conn_owner,
      conn_input_only,
      conn_listen_only
   } conn_type_type;

   // ==========================================
   // process data sizes in bytes and input byte indices
   localparam int unsigned IN_DATA_BYTES      = 5;
   localparam int unsigned OUT_DATA_BYTES_OWN = 1;
   localparam int unsigned CFG_DATA_BYTES     = 2;
   localparam logic [2:0]  IN_LAST_BYTE       = 3'h4;
   localparam logic [2:0]  IN_SENSE_BYTE      = 3'h4;

   // data set numbers
   localparam logic [7:0] DATASET_OUT = 8'h64;
   localparam logic [7:0] DATASET_IN  = 8'h65;
   localparam logic [7:0] DATASET_CFG = 8'h66;

   // ==========================================
   // configuration byte offsets, reset values and mode limit
   localparam logic       CFG_MODE_OFFSET    = 1'h0;
   localparam logic       CFG_PATTERN_OFFSET = 1'h1;
   localparam logic [1:0] MODE_RESET         = 2'h0;
   localparam logic [7:0] PATTERN_RESET      = 8'h00;
   localparam logic [7:0] MODE_MAX           = 8'h03;

   // substitute modes
   localparam logic [1:0] MODE_ALL_LOW  = 2'h0;
   localparam logic [1:0] MODE_ALL_HIGH = 2'h1;
   localparam logic [1:0] MODE_HOLD     = 2'h2;
   localparam logic [1:0] MODE_PATTERN  = 2'h3;

   // ==========================================
   // status word layout
   localparam int unsigned ST_OUT_SHORT     = 0;
   localparam int unsigned ST_OUT_OVERLOAD  = 1;
   localparam int unsigned ST_RAIL_SHORT    = 2;
   localparam int unsigned ST_RAIL_UNDERV   = 3;
   localparam int unsigned ST_LOGIC_OVERLD  = 4;
   localparam int unsigned ST_LOGIC_UNDERV  = 5;
   localparam int unsigned ST_FLAG_BITS     = 6;
   localparam logic [25:0] ST_RESERVED      = 26'h000_0000;

   // ==========================================
   // switch position that restores delivery defaults
   localparam logic [3:0] RESTORE_POSITION = 4'hF;

   // ==========================================
   // timing
   localparam int unsigned CLK_KHZ        = 40000;
   localparam int unsigned CLK_MHZ        = 40;
   localparam int unsigned ACCEPT_MS      = 350;
   localparam int unsigned CYCLIC_MS      = 500;
   localparam int unsigned RING_US        = 3000;
   localparam int unsigned FLASH_HALF_MS  = 250;
   // longest times round down; the ring bound is strict, hence the minus one
   localparam int unsigned ACCEPT_CYCLES  = ACCEPT_MS * CLK_KHZ;
   localparam int unsigned CYCLIC_CYCLES  = CYCLIC_MS * CLK_KHZ;
   localparam int unsigned RING_CYCLES    = RING_US * CLK_MHZ - 1;
   localparam int unsigned FLASH_CYCLES   = FLASH_HALF_MS * CLK_KHZ;

endpackage

// >>> rtl/io_process_image.sv
// process-image core: data sets, configuration, startup timing and lamps
// Summary of operation
// - every connection type returns five input bytes to the scanner.
// - owner connections carry one output byte; other types carry none.
// - owner and input-only carry two config bytes; listen-only carries none.
// - output data set 100; bit n drives output channel n+1.
// - the output byte holds channels 1 to 8 only.
// - input data set 101; bytes 0-3 status word, byte 4 sense channels.
// - byte 4 bit n reflects sense channel n+1.
// - status word bits 31 down to 6 read zero.
// - status bits 0-5: output short/overload, rail short/undervoltage, logic supply.
// - config byte 0 picks substitute mode 0 to 3, default 0.
// - config byte 1 is the pattern, used only in mode 3.
// - ready for connection requests within 350 ms of power up.
// - cyclic connection possible within 500 ms of power up.
// - network lamp green, steady or flashing, once boot completes.
// - ready lamp flashes yellow during a firmware update.
// - switch position 0F restores delivery defaults.
// - ring loss detected and reconfigured in under 3 ms.
`timescale 1ns/1ps
`default_nettype none
module io_process_image #(
   parameter int unsigned ACCEPT_CYCLES = io_image_pkg::ACCEPT_CYCLES,
   parameter int unsigned CYCLIC_CYCLES = io_image_pkg::CYCLIC_CYCLES,
   parameter int unsigned RING_CYCLES   = io_image_pkg::RING_CYCLES,
   parameter int unsigned FLASH_CYCLES  = io_image_pkg::FLASH_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   // connection management
   input  wire logic       conn_open_req,
   input  wire logic [1:0] conn_open_type,
   input  wire logic       conn_open_multicast,
   input  wire logic       conn_close,
   output logic            conn_accepted_q,
   output logic            conn_refused_q,
   output logic [1:0]      conn_state_q,
   // output data set
   input  wire logic       out_wr,
   input  wire logic [7:0] out_wr_data,
   output logic [7:0]      out_channel_q,
   // input data set
   input  wire logic       in_rd,
   input  wire logic [2:0] in_rd_index,
   output logic [7:0]      in_rd_data_q,
   output logic            in_rd_valid_q,
   // configuration data set
   input  wire logic       cfg_wr,
   input  wire logic       cfg_wr_index,
   input  wire logic [7:0] cfg_wr_data,
   output logic            cfg_wr_error_q,
   output logic [1:0]      cfg_mode_q,
   output logic [7:0]      cfg_pattern_q,
   // field side
   input  wire logic [7:0] device_sense_channel,
   input  wire logic [5:0] fault_flags,
   // system
   input  wire logic [3:0] rotary_position,
   input  wire logic       fw_update_active,
   input  wire logic       ring_segment_lost,
   output logic            ring_reconfigured_q,
   output logic            accept_ready_q,
   output logic            cyclic_ready_q,
   output logic            defaults_restored_q,
   output logic            net_lamp_green_q,
   output logic            ready_lamp_yellow_q
);

   // ==========================================
   // helpers
   function automatic logic type_has_cfg(input logic [1:0] t);
      return (t == io_image_pkg::conn_owner) || (t == io_image_pkg::conn_input_only);
   endfunction

   function automatic logic done_at(input logic [31:0] cnt, input int unsigned lim);
      return cnt >= lim[31:0];
   endfunction

   substitute_if sub ();

   logic [31:0] boot_cnt_q;
   logic [31:0] ring_cnt_q;
   logic [31:0] flash_cnt_q;
   logic        ring_busy_q;
   logic        ring_lost_q;
   logic        flash_phase_q;
   logic        flash_tick;
   logic [7:0]  out_data_q;
   logic [7:0]  sense_q;
   logic [31:0] status_q;
   logic        restore;
   logic        owner_live;
   logic        open_ok;

   // ==========================================
   // startup timers
   // accept and cyclic windows
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         boot_cnt_q     <= 32'h0000_0000;
         accept_ready_q <= 1'b0;
         cyclic_ready_q <= 1'b0;
      end else begin
         if (!done_at(boot_cnt_q, CYCLIC_CYCLES)) begin
            boot_cnt_q <= boot_cnt_q + 32'h0000_0001;
         end
         if (done_at(boot_cnt_q, ACCEPT_CYCLES - 1)) begin
            accept_ready_q <= 1'b1;
         end
         if (done_at(boot_cnt_q, CYCLIC_CYCLES - 1)) begin
            cyclic_ready_q <= 1'b1;
         end
      end
   end

   // ==========================================
   // connection management
   // listen-only must be multicast
   assign open_ok = accept_ready_q
                  && (conn_state_q == io_image_pkg::conn_none)
                  && (conn_open_type != io_image_pkg::conn_none)
                  && !((conn_open_type == io_image_pkg::conn_listen_only)
                       && !conn_open_multicast);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conn_state_q    <= io_image_pkg::conn_none;
         conn_accepted_q <= 1'b0;
         conn_refused_q  <= 1'b0;
      end else begin
         conn_accepted_q <= 1'b0;
         conn_refused_q  <= 1'b0;
         if (conn_close) begin
            conn_state_q <= io_image_pkg::conn_none;
         end else if (conn_open_req) begin
            if (open_ok) begin
               conn_state_q    <= conn_open_type;
               conn_accepted_q <= 1'b1;
            end else begin
               conn_refused_q <= 1'b1;
            end
         end
      end
   end

   // ==========================================
   // output data set
   // cyclic data only once startup allows it
   assign owner_live = cyclic_ready_q && (conn_state_q == io_image_pkg::conn_owner);

   // only an owner carries output data
   // whole byte is channels 1 to 8
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_data_q <= 8'h00;
      end else if (out_wr && owner_live) begin
         out_data_q <= out_wr_data;
      end
   end

   assign sub.mode         = cfg_mode_q;
   assign sub.pattern      = cfg_pattern_q;
   assign sub.scanner_data = out_data_q;
   // scanner data only while owner is live
   assign sub.owner_live   = owner_live;

   substitute_select u_select (
      .clk   (clk),
      .rst_n (rst_n),
      .sel   (sub.selector)
   );

   // selector holds the flop; mirror it so the port is registered here too
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_channel_q <= 8'h00;
      end else begin
         out_channel_q <= sub.drive;
      end
   end

   // ==========================================
   // input data set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sense_q  <= 8'h00;
         status_q <= 32'h0000_0000;
      end else begin
         sense_q  <= device_sense_channel;
         status_q <= {io_image_pkg::ST_RESERVED,
                      fault_flags[io_image_pkg::ST_LOGIC_UNDERV],
                      fault_flags[io_image_pkg::ST_LOGIC_OVERLD],
                      fault_flags[io_image_pkg::ST_RAIL_UNDERV],
                      fault_flags[io_image_pkg::ST_RAIL_SHORT],
                      fault_flags[io_image_pkg::ST_OUT_OVERLOAD],
                      fault_flags[io_image_pkg::ST_OUT_SHORT]};
      end
   end

   // five bytes for any open connection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_rd_data_q  <= 8'h00;
         in_rd_valid_q <= 1'b0;
      end else begin
         in_rd_valid_q <= 1'b0;
         if (in_rd && (conn_state_q != io_image_pkg::conn_none)
             && (in_rd_index <= io_image_pkg::IN_LAST_BYTE)) begin
            in_rd_valid_q <= 1'b1;
            if (in_rd_index == io_image_pkg::IN_SENSE_BYTE) begin
               in_rd_data_q <= sense_q;
            end else begin
               in_rd_data_q <= status_q[{in_rd_index[1:0], 3'h0} +: 8];
            end
         end
      end
   end

   // ==========================================
   // configuration data set
   assign restore = (rotary_position == io_image_pkg::RESTORE_POSITION);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_mode_q     <= io_image_pkg::MODE_RESET;
         cfg_pattern_q  <= io_image_pkg::PATTERN_RESET;
         cfg_wr_error_q <= 1'b0;
      end else begin
         cfg_wr_error_q <= 1'b0;
         if (restore) begin
            cfg_mode_q    <= io_image_pkg::MODE_RESET;
            cfg_pattern_q <= io_image_pkg::PATTERN_RESET;
         end else if (cfg_wr) begin
            if (!type_has_cfg(conn_state_q)) begin
               cfg_wr_error_q <= 1'b1;
            end else if (cfg_wr_index == io_image_pkg::CFG_MODE_OFFSET) begin
               if (cfg_wr_data > io_image_pkg::MODE_MAX) begin
                  cfg_wr_error_q <= 1'b1;
               end else begin
                  cfg_mode_q <= cfg_wr_data[1:0];
               end
            end else begin
               cfg_pattern_q <= cfg_wr_data;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         defaults_restored_q <= 1'b0;
      end else begin
         defaults_restored_q <= restore;
      end
   end

   // ==========================================
   // ring reconfiguration
   // fixed latency below 3 ms
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ring_lost_q         <= 1'b0;
         ring_busy_q         <= 1'b0;
         ring_cnt_q          <= 32'h0000_0000;
         ring_reconfigured_q <= 1'b0;
      end else begin
         ring_lost_q         <= ring_segment_lost;
         ring_reconfigured_q <= 1'b0;
         if (ring_segment_lost && !ring_lost_q && !ring_busy_q) begin
            ring_busy_q <= 1'b1;
            ring_cnt_q  <= 32'h0000_0000;
         end else if (ring_busy_q) begin
            if (done_at(ring_cnt_q, RING_CYCLES - 1)) begin
               ring_busy_q         <= 1'b0;
               ring_reconfigured_q <= 1'b1;
            end else begin
               ring_cnt_q <= ring_cnt_q + 32'h0000_0001;
            end
         end
      end
   end

   // ==========================================
   // lamps
   assign flash_tick = done_at(flash_cnt_q, FLASH_CYCLES - 1);

   // flash divider gives a one-cycle enable each half period
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_cnt_q   <= 32'h0000_0000;
         flash_phase_q <= 1'b0;
      end else if (flash_tick) begin
         flash_cnt_q   <= 32'h0000_0000;
         flash_phase_q <= !flash_phase_q;
      end else begin
         flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
      end
   end

   // green after boot: steady with connection, flashing without
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         net_lamp_green_q    <= 1'b0;
         ready_lamp_yellow_q <= 1'b0;
      end else begin
         if (!accept_ready_q) begin
            net_lamp_green_q <= 1'b0;
         end else if (conn_state_q != io_image_pkg::conn_none) begin
            net_lamp_green_q <= 1'b1;
         end else begin
            net_lamp_green_q <= flash_phase_q;
         end
         ready_lamp_yellow_q <= fw_update_active && flash_phase_q;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/substitute_if.sv
// carrier between the process-image core and the output selector
`timescale 1ns/1ps
`default_nettype none
interface substitute_if;
   logic [1:0] mode;
   logic [7:0] pattern;
   logic [7:0] scanner_data;
   logic       owner_live;
   logic [7:0] drive;

   modport selector (
      input  mode,
      input  pattern,
      input  scanner_data,
      input  owner_live,
      output drive
   );
   modport core (
      output mode,
      output pattern,
      output scanner_data,
      output owner_live,
      input  drive
   );
endinterface
`default_nettype wire

// >>> rtl/substitute_select.sv
// output channel selector between scanner data and substitute values
`timescale 1ns/1ps
`default_nettype none
module substitute_select (
   input  wire logic     clk,
   input  wire logic     rst_n,
   substitute_if.selector sel
);

   logic [7:0] drive_q;
   logic [7:0] drive_d;

   // ==========================================
   // choice of drive value
   always_comb begin
      drive_d = drive_q;
      if (sel.owner_live) begin
         drive_d = sel.scanner_data;
      end else begin
         case (sel.mode)
            io_image_pkg::MODE_ALL_LOW:  drive_d = 8'h00;
            io_image_pkg::MODE_ALL_HIGH: drive_d = 8'hFF;
            io_image_pkg::MODE_HOLD:     drive_d = drive_q;
            default:                     drive_d = sel.pattern;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drive_q <= 8'h00;
      end else begin
         drive_q <= drive_d;
      end
   end

   assign sel.drive = drive_q;

endmodule
`default_nettype wire

// >>> tb/io_process_image_chk.sv
// concurrent checks on the process-image core ports
`timescale 1ns/1ps
`default_nettype none
module io_process_image_chk #(
   parameter int unsigned RING_CYCLES = 12
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       conn_open_req,
   input wire logic [1:0] conn_open_type,
   input wire logic       conn_open_multicast,
   input wire logic       conn_close,
   input wire logic       conn_refused_q,
   input wire logic [1:0] conn_state_q,
   input wire logic       conn_accepted_q,
   input wire logic       out_wr,
   input wire logic [7:0] out_wr_data,
   input wire logic [7:0] out_channel_q,
   input wire logic       cyclic_ready_q,
   input wire logic       accept_ready_q,
   input wire logic       in_rd,
   input wire logic [2:0] in_rd_index,
   input wire logic [7:0] in_rd_data_q,
   input wire logic       in_rd_valid_q,
   input wire logic [7:0] device_sense_channel,
   input wire logic [5:0] fault_flags,
   input wire logic       cfg_wr,
   input wire logic       cfg_wr_index,
   input wire logic [7:0] cfg_wr_data,
   input wire logic       cfg_wr_error_q,
   input wire logic [1:0] cfg_mode_q,
   input wire logic [7:0] cfg_pattern_q,
   input wire logic [3:0] rotary_position,
   input wire logic       ring_segment_lost,
   input wire logic       ring_reconfigured_q,
   input wire logic       fw_update_active,
   input wire logic       ready_lamp_yellow_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==========================================
   // cycles since the last ring loss, saturating so a stale count never wraps
   logic [15:0] ring_cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ring_cnt_q <= 16'h0000;
      end else if ($rose(ring_segment_lost)) begin
         ring_cnt_q <= 16'h0001;
      end else if (ring_cnt_q != 16'h0000 && ring_cnt_q != 16'hFFFF) begin
         ring_cnt_q <= ring_cnt_q + 16'h0001;
      end
   end

   // ==========================================
   // assertions
   AST_OPEN_EARLY: assert property (conn_open_req && !conn_close && !accept_ready_q
      |=> conn_refused_q && !conn_accepted_q) else $error("open accepted before ready");
   AST_LISTEN_UNICAST: assert property (conn_open_req && !conn_close
      && conn_open_type == 2'h3 && !conn_open_multicast |=> conn_refused_q)
      else $error("unicast listen-only accepted");
   AST_OUT_PATH: assert property (out_wr && cyclic_ready_q && conn_state_q == 2'h1
      && !conn_close |-> ##3 out_channel_q == $past(out_wr_data, 3))
      else $error("output byte not driven");
   AST_READ_ANSWER: assert property (in_rd && conn_state_q != 2'h0 && in_rd_index <= 3'h4
      |=> in_rd_valid_q) else $error("input byte read not answered");
   AST_READ_RANGE: assert property (in_rd && in_rd_index > 3'h4 |=> !in_rd_valid_q)
      else $error("read beyond byte 4 answered");
   AST_SENSE: assert property (in_rd_valid_q && $past(in_rd_index) == 3'h4
      |-> in_rd_data_q == $past(device_sense_channel, 2)) else $error("sense byte wrong");
   AST_STATUS: assert property (in_rd_valid_q && $past(in_rd_index) == 3'h0
      |-> in_rd_data_q == {2'h0, $past(fault_flags, 2)}) else $error("status flags wrong");
   AST_RESERVED: assert property (in_rd_valid_q
      && $past(in_rd_index) inside {3'h1, 3'h2, 3'h3} |-> in_rd_data_q == 8'h00)
      else $error("reserved status bits set");
   AST_MODE_LIMIT: assert property (cfg_wr && !cfg_wr_index && cfg_wr_data > 8'h03
      && rotary_position != 4'hF |=> cfg_wr_error_q && $stable(cfg_mode_q))
      else $error("out of range mode taken");
   AST_LISTEN_CFG: assert property (cfg_wr && conn_state_q == 2'h3
      && rotary_position != 4'hF |=> cfg_wr_error_q) else $error("config taken on listen-only");
   AST_RESTORE: assert property (rotary_position == 4'hF ##1 rotary_position == 4'hF
      |-> cfg_mode_q == 2'h0 && cfg_pattern_q == 8'h00) else $error("defaults not restored");
   AST_RING: assert property (ring_reconfigured_q
      |-> ring_cnt_q inside {[RING_CYCLES:RING_CYCLES + 1]}) else $error("ring reconfig late");
   AST_YELLOW_IDLE: assert property (!fw_update_active ##1 !fw_update_active
      |-> !ready_lamp_yellow_q) else $error("yellow lamp without update");

   COV_OWNER: cover property (conn_accepted_q && conn_state_q == 2'h1);
   COV_CFG_ERR: cover property (cfg_wr_error_q);
   COV_RING: cover property (ring_reconfigured_q);
endmodule

bind io_process_image io_process_image_chk #(.RING_CYCLES(RING_CYCLES)) chk_u (.*);
`default_nettype wire

// >>> tb/scanner_model.sv
// scanner model: opens connections and exchanges cyclic data with the device
`timescale 1ns/1ps
`default_nettype none
module scanner_model (
   input  wire logic       clk,
   output logic            conn_open_req,
   output logic [1:0]      conn_open_type,
   output logic            conn_open_multicast,
   output logic            conn_close,
   input  wire logic       conn_accepted_q,
   input  wire logic       conn_refused_q,
   output logic            out_wr,
   output logic [7:0]      out_wr_data,
   output logic            in_rd,
   output logic [2:0]      in_rd_index,
   input  wire logic [7:0] in_rd_data_q,
   input  wire logic       in_rd_valid_q,
   output logic            cfg_wr,
   output logic            cfg_wr_index,
   output logic [7:0]      cfg_wr_data,
   input  wire logic       cfg_wr_error_q
);
   initial begin
      {conn_open_req, conn_open_type, conn_open_multicast, conn_close} = 5'h00;
      {out_wr, out_wr_data, in_rd, in_rd_index} = 13'h0000;
      {cfg_wr, cfg_wr_index, cfg_wr_data} = 10'h000;
   end

   // listen-only unicast only when the bench asks for it
   task automatic open_conn(input logic [1:0] kind, input logic mcast, output logic [1:0] ans);
      @(posedge clk);
      #1 {conn_open_req, conn_open_type, conn_open_multicast} = {1'b1, kind, mcast};
      @(posedge clk);
      #1 conn_open_req = 1'b0;
      ans = {conn_accepted_q, conn_refused_q};
   endtask

   task automatic close_conn();
      @(posedge clk);
      #1 conn_close = 1'b1;
      @(posedge clk);
      #1 conn_close = 1'b0;
   endtask

   task automatic write_out(input logic [7:0] d);
      @(posedge clk);
      #1 {out_wr, out_wr_data} = {1'b1, d};
      @(posedge clk);
      #1 out_wr = 1'b0;
   endtask

   task automatic cfg_write(input logic idx, input logic [7:0] d, output logic err);
      @(posedge clk);
      #1 {cfg_wr, cfg_wr_index, cfg_wr_data} = {1'b1, idx, d};
      @(posedge clk);
      #1 cfg_wr = 1'b0;
      err = cfg_wr_error_q;
   endtask

   task automatic read_byte(input logic [2:0] idx, output logic v, output logic [7:0] d);
      @(posedge clk);
      #1 {in_rd, in_rd_index} = {1'b1, idx};
      @(posedge clk);
      #1 in_rd = 1'b0;
      v = in_rd_valid_q;
      d = in_rd_data_q;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the process-image core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int unsigned ACC  = 35;
   localparam int unsigned CYC  = 50;
   localparam int unsigned RING = 12;
   logic       clk, rst_n, conn_open_req, conn_open_multicast, conn_close, conn_accepted_q;
   logic       conn_refused_q, out_wr, in_rd, in_rd_valid_q, cfg_wr, cfg_wr_index;
   logic       cfg_wr_error_q, fw_update_active, ring_segment_lost, ring_reconfigured_q;
   logic       accept_ready_q, cyclic_ready_q, defaults_restored_q, net_lamp_green_q;
   logic       ready_lamp_yellow_q, v, e;
   logic [1:0] conn_open_type, conn_state_q, cfg_mode_q, ans;
   logic [2:0] in_rd_index;
   logic [3:0] rotary_position;
   logic [5:0] fault_flags;
   logic [7:0] out_wr_data, out_channel_q, in_rd_data_q, cfg_wr_data, cfg_pattern_q;
   logic [7:0] device_sense_channel, d;
   logic [7:0] mexp [4] = '{8'hA5, 8'h00, 8'hFF, 8'h5A};
   logic [1:0] mseq [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
   logic [7:0] rexp [5] = '{8'h2A, 8'h00, 8'h00, 8'h00, 8'hC3};
   int         err_count, n_tests, n, cyc;

   io_process_image #(.ACCEPT_CYCLES(ACC), .CYCLIC_CYCLES(CYC), .RING_CYCLES(RING),
      .FLASH_CYCLES(4)) dut_u (.*);
   scanner_model scanner_u (.*);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask

   // a hung handshake still ends in the closing report
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      {rst_n, fw_update_active, ring_segment_lost} = 3'h0;
      {device_sense_channel, fault_flags, rotary_position} = 18'h0_0000;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      @(posedge clk);
      #1 cmp_byte({6'h00, cfg_mode_q}, 8'h00);
      cmp_byte(cfg_pattern_q, 8'h00);
      scanner_u.open_conn(2'h1, 1'b0, ans);
      cmp_byte({6'h00, ans}, 8'h01);
      n = 2;
      while (accept_ready_q !== 1'b1 && n < 200) begin
         cmp_bit(net_lamp_green_q, 1'b0);
         @(posedge clk);
         #1 n++;
      end
      cmp_bit(n <= ACC, 1'b1);
      while (cyclic_ready_q !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      cmp_bit(n <= CYC, 1'b1);
      scanner_u.open_conn(2'h1, 1'b0, ans);
      cmp_byte({6'h00, ans}, 8'h02);
      cmp_byte({6'h00, conn_state_q}, 8'h01);
      for (int i = 0; i < 9; i++) begin
         d = (i < 8) ? 8'h01 << i : 8'hA5;
         scanner_u.write_out(d);
         repeat (2) @(posedge clk);
         #1 cmp_byte(out_channel_q, d);
      end
      cmp_bit(net_lamp_green_q, 1'b1);
      scanner_u.cfg_write(1'b0, 8'h02, e);
      cmp_bit(e, 1'b0);
      scanner_u.close_conn();
      repeat (4) @(posedge clk);
      #1 cmp_byte(out_channel_q, 8'hA5);
      scanner_u.open_conn(2'h2, 1'b0, ans);
      cmp_byte({6'h00, ans}, 8'h02);
      scanner_u.write_out(8'h00);
      repeat (3) @(posedge clk);
      #1 cmp_byte(out_channel_q, 8'hA5);
      scanner_u.cfg_write(1'b1, 8'h5A, e);
      cmp_byte(cfg_pattern_q, 8'h5A);
      for (int i = 0; i < 4; i++) begin
         scanner_u.cfg_write(1'b0, {6'h00, mseq[i]}, e);
         repeat (3) @(posedge clk);
         #1 cmp_byte(out_channel_q, mexp[i]);
      end
      scanner_u.cfg_write(1'b0, 8'h04, e);
      cmp_bit(e, 1'b1);
      fault_flags = 6'h2A;
      device_sense_channel = 8'hC3;
      for (int i = 0; i < 6; i++) begin
         scanner_u.read_byte(3'(i), v, d);
         cmp_bit(v, i < 5);
         if (i < 5) cmp_byte(d, rexp[i]);
      end
      scanner_u.close_conn();
      scanner_u.open_conn(2'h3, 1'b0, ans);
      cmp_byte({6'h00, ans}, 8'h01);
      scanner_u.open_conn(2'h3, 1'b1, ans);
      cmp_byte({6'h00, ans}, 8'h02);
      scanner_u.cfg_write(1'b1, 8'h11, e);
      cmp_bit(e, 1'b1);
      scanner_u.read_byte(3'h4, v, d);
      cmp_byte(d, 8'hC3);
      scanner_u.close_conn();
      rotary_position = 4'hF;
      repeat (2) @(posedge clk);
      #1 cmp_bit(defaults_restored_q, 1'b1);
      cmp_byte({6'h00, cfg_mode_q}, 8'h00);
      cmp_byte(cfg_pattern_q, 8'h00);
      rotary_position = 4'h0;
      // owner returns: scanner data replaces the substitute value
      scanner_u.open_conn(2'h1, 1'b0, ans);
      scanner_u.write_out(8'h3C);
      repeat (2) @(posedge clk);
      #1 cmp_byte(out_channel_q, 8'h3C);
      ring_segment_lost = 1'b1;
      n = 0;
      while (ring_reconfigured_q !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      cmp_bit(n >= RING && n <= RING + 1, 1'b1);
      cmp_bit(ready_lamp_yellow_q, 1'b0);
      fw_update_active = 1'b1;
      n = 0;
      repeat (16) begin
         @(posedge clk);
         #1 n += int'(ready_lamp_yellow_q === 1'b1);
      end
      cmp_byte(8'(n), 8'h08);
      end_sim();
   end
endmodule
`default_nettype wire
